// *** dv/mdsd_asserts.sv ***
`timescale 1ns/100ps
module mdsd_asserts (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input mdsd_pkg::mdsd_mul_req_t alu_mul_i,
	input mdsd_pkg::mdsd_mul_req_t dsp_mul_i,
	input wire logic [33:0] alu_prod_o,
	input wire logic [33:0] dsp_prod_o,
	input wire logic alu_mul_gnt_o,
	input wire logic dsp_mul_gnt_o,
	input mdsd_pkg::mdsd_sh_req_t dsp_sh_i,
	input wire logic [39:0] dsp_sh_o,
	input wire logic alu_sh_gnt_o,
	input wire logic dsp_sh_gnt_o,
	input wire logic irq_hold_i,
	input mdsd_pkg::mdsd_div_res_t div_res_o,
	input wire logic div_busy_o,
	input wire logic div_done_o
);
	// ----
	// Checks
	// ----
	logic [33:0] ss_p;
	logic [39:0] sl_p;
	assign ss_p = $signed(dsp_mul_i.a) * $signed(dsp_mul_i.b);
	assign sl_p = dsp_sh_i.data << dsp_sh_i.amount;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	a_mul_prio: assert property (dsp_mul_i.valid |->
		dsp_mul_gnt_o && !alu_mul_gnt_o) else $error("mul grant");
	a_prod_hold: assert property (!alu_mul_gnt_o |=>
		$stable(alu_prod_o)) else $error("product moved");
	a_ss_prod: assert property (dsp_mul_gnt_o &&
		dsp_mul_i.mode == mdsd_pkg::MDSD_MUL_SS |=>
		dsp_prod_o == $past(ss_p)) else $error("signed product");
	a_sh_left: assert property (dsp_sh_gnt_o &&
		dsp_sh_i.dir == mdsd_pkg::MDSD_SH_LEFT && dsp_sh_i.amount <= 5'h10
		|=> dsp_sh_o == $past(sl_p)) else $error("left shift");
	a_sh_prio: assert property (dsp_sh_i.valid |->
		dsp_sh_gnt_o && !alu_sh_gnt_o) else $error("shift grant");
	a_done_pulse: assert property (div_done_o |=>
		!div_done_o) else $error("done too long");
	a_irq_freeze: assert property (irq_hold_i && div_busy_o |=>
		$stable(div_busy_o) && $stable(div_res_o) && !div_done_o)
		else $error("divider not frozen");
	a_done_busy: assert property ($rose(div_done_o) |->
		$past(div_busy_o) || $past(div_busy_o, 2)) else $error("stray done");
	c_mul_clash: cover property (dsp_mul_i.valid && alu_mul_i.valid);
	c_div_irq: cover property (irq_hold_i && div_busy_o);
	c_done: cover property (div_done_o);
endmodule // mdsd_asserts
bind mdsd_datapath mdsd_asserts u_mdsd_asserts (.*);

// *** dv/mdsd_datapath_tb.sv ***
`timescale 1ns/100ps
module mdsd_datapath_tb;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic irq_en = 1'b0;
	logic irq_hold_i;
	mdsd_pkg::mdsd_mul_req_t alu_mul_i = '0, dsp_mul_i = '0;
	mdsd_pkg::mdsd_sh_req_t alu_sh_i = '0, dsp_sh_i = '0;
	mdsd_pkg::mdsd_div_req_t div_i = '0;
	mdsd_pkg::mdsd_div_res_t div_res_o;
	logic [33:0] alu_prod_o, dsp_prod_o;
	logic [39:0] alu_sh_o, dsp_sh_o;
	logic alu_mul_gnt_o, dsp_mul_gnt_o, alu_sh_gnt_o, dsp_sh_gnt_o;
	logic div_busy_o, div_done_o;
	int failures = 0;
	int total_checks = 0;
	mdsd_datapath u_mdsd_datapath (.*);
	mdsd_irq_model u_mdsd_irq_model (.clk_sys_i, .rst_n_i, .en_i(irq_en),
		.irq_hold_o(irq_hold_i));
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// ----
	// Helpers
	// ----
	task automatic end_of_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [33:0] mexp(input int m, input logic [15:0] a,
		input logic [15:0] b);
		logic signed [16:0] x, y;
		x = {a[15] & (m == 0 || m == 2), a};
		y = {b[15] & (m == 0 || m == 3), b};
		return x * y;
	endfunction
	task automatic t_mul;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys_i);
			alu_mul_i <= '{1'b1, mdsd_pkg::mdsd_mul_mode_t'(i), 16'hffff, 16'h8000};
			dsp_mul_i <= '{1'b1, mdsd_pkg::mdsd_mul_mode_t'(i), 16'h8000, 16'h8000};
			#1 chk(alu_mul_gnt_o, 40'h0);
			chk(dsp_mul_gnt_o, 40'h1);
			@(posedge clk_sys_i) dsp_mul_i.valid <= 1'b0;
			#1 chk(alu_mul_gnt_o, 40'h1);
			@(posedge clk_sys_i) alu_mul_i.valid <= 1'b0;
			#1 chk(alu_prod_o, mexp(i, 16'hffff, 16'h8000));
			chk(dsp_prod_o, mexp(i, 16'h8000, 16'h8000));
		end
		$display("t_mul done");
	endtask
	task automatic t_sh;
		@(posedge clk_sys_i);
		dsp_sh_i <= '{1'b1, mdsd_pkg::MDSD_SH_LEFT, 1'b0, 5'h10, 40'h1234};
		alu_sh_i <= '{1'b1, mdsd_pkg::MDSD_SH_RIGHT, 1'b1, 5'h14, 40'h8000000000};
		#1 chk(alu_sh_gnt_o, 40'h0);
		chk(dsp_sh_gnt_o, 40'h1);
		@(posedge clk_sys_i) dsp_sh_i.valid <= 1'b0;
		#1 chk(alu_sh_gnt_o, 40'h1);
		@(posedge clk_sys_i) alu_sh_i.valid <= 1'b0;
		#1 chk(dsp_sh_o, 40'h0012340000);
		chk(alu_sh_o, 40'hffff800000);
		@(posedge clk_sys_i);
		dsp_sh_i <= '{1'b1, mdsd_pkg::MDSD_SH_RIGHT, 1'b0, 5'h04, 40'h8000000000};
		@(posedge clk_sys_i) dsp_sh_i.valid <= 1'b0;
		#1 chk(dsp_sh_o, 40'h0800000000);
		$display("t_sh done");
	endtask
	task automatic div_run(input logic [2:0] md, input logic [31:0] n,
		input logic [15:0] d, input logic [31:0] e);
		int k;
		logic adv_seen;
		k = 0;
		@(posedge clk_sys_i);
		div_i <= '{1'b1, md[2], mdsd_pkg::mdsd_div_mode_t'(md[1:0]), n, d};
		irq_en <= 1'b1;
		for (int w = 0; w < 99 && k < mdsd_pkg::MDSD_DIV_CYCLES; w++) begin
			#1 adv_seen = (irq_hold_i === 1'b0);
			chk(div_done_o, 40'h0);
			@(posedge clk_sys_i);
			if (adv_seen) k++;
		end
		div_i.step <= 1'b0;
		irq_en <= 1'b0;
		#1;
		for (int w = 0; w < 4 && div_done_o !== 1'b1; w++) begin
			@(posedge clk_sys_i);
			#1;
		end
		if (k < mdsd_pkg::MDSD_DIV_CYCLES || div_done_o !== 1'b1) begin
			failures++;
			end_of_test();
		end else begin
			chk(div_res_o, e);
			chk(div_busy_o, 40'h0);
		end
	endtask
	task automatic t_div;
		div_run(3'h0, 32'h0000fff9, 16'h0002, 32'hfffdffff);
		div_run(3'h1, 32'h0000fff9, 16'h0002, 32'h7ffc0001);
		div_run(3'h2, 32'hfffe0000, 16'h0004, 32'h80000000);
		div_run(3'h3, 32'h00012345, 16'h0010, 32'h12340005);
		div_run(3'h5, 32'h00004000, 16'h8000, 32'h80000000);
		div_run(3'h4, 32'h0000f000, 16'h4000, 32'hc0000000);
		div_run(3'h3, 32'hfffe0001, 16'hffff, 32'hffff0000);
		$display("t_div done");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_mul();
		t_sh();
		t_div();
		end_of_test();
	end
endmodule // mdsd_datapath_tb

// *** dv/mdsd_irq_model.sv ***
`timescale 1ns/100ps
module mdsd_irq_model (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	output logic irq_hold_o
);
	logic [1:0] cnt;
	// Interrupt two cycles in four mid-divide
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) cnt <= 2'h0;
		else cnt <= en_i ? cnt + 2'h1 : 2'h0;
	end
	assign irq_hold_o = cnt[1];
endmodule // mdsd_irq_model

// *** rtl/mdsd_datapath.sv ***
`timescale 1ns/100ps
module mdsd_datapath (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input mdsd_pkg::mdsd_mul_req_t alu_mul_i,
	input mdsd_pkg::mdsd_mul_req_t dsp_mul_i,
	output logic [33:0] alu_prod_o,
	output logic [33:0] dsp_prod_o,
	output logic alu_mul_gnt_o,
	output logic dsp_mul_gnt_o,
	input mdsd_pkg::mdsd_sh_req_t alu_sh_i,
	input mdsd_pkg::mdsd_sh_req_t dsp_sh_i,
	output logic [39:0] alu_sh_o,
	output logic [39:0] dsp_sh_o,
	output logic alu_sh_gnt_o,
	output logic dsp_sh_gnt_o,
	input mdsd_pkg::mdsd_div_req_t div_i,
	input wire logic irq_hold_i,
	output mdsd_pkg::mdsd_div_res_t div_res_o,
	output logic div_busy_o,
	output logic div_done_o
);

	// ---------------------------------------------------------------
	// Multiplier
	// ---------------------------------------------------------------
	mdsd_pkg::mdsd_mul_req_t mul_sel;
	logic mul_dsp;
	logic a_sgn;
	logic b_sgn;
	logic signed [16:0] a_ext;
	logic signed [16:0] b_ext;
	logic signed [33:0] product;

	// DSP engine has priority on a collision
	assign mul_dsp = dsp_mul_i.valid;
	assign mul_sel = mul_dsp ? dsp_mul_i : alu_mul_i;
	assign dsp_mul_gnt_o = dsp_mul_i.valid;
	assign alu_mul_gnt_o = alu_mul_i.valid & ~dsp_mul_i.valid;

	always_comb begin
		a_sgn = 1'b0;
		b_sgn = 1'b0;
		case (mul_sel.mode)
			mdsd_pkg::MDSD_MUL_SS: begin
				a_sgn = 1'b1;
				b_sgn = 1'b1;
			end
			mdsd_pkg::MDSD_MUL_SU: a_sgn = 1'b1;
			mdsd_pkg::MDSD_MUL_US: b_sgn = 1'b1;
			default: begin
				a_sgn = 1'b0;
				b_sgn = 1'b0;
			end
		endcase
	end

	// Extension to 17 bits makes -1.0 x -1.0 exact
	assign a_ext = {a_sgn & mul_sel.a[15], mul_sel.a};
	assign b_ext = {b_sgn & mul_sel.b[15], mul_sel.b};
	assign product = a_ext * b_ext;

	// ---------------------------------------------------------------
	// Multiplier result
	// ---------------------------------------------------------------

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alu_prod_o <= 34'h0;
			dsp_prod_o <= 34'h0;
		end else begin
			if (mul_sel.valid && mul_dsp) begin
				dsp_prod_o <= product;
			end
			if (mul_sel.valid && !mul_dsp) begin
				alu_prod_o <= product;
			end
		end
	end

	// ---------------------------------------------------------------
	// Barrel shifter
	// ---------------------------------------------------------------
	mdsd_pkg::mdsd_sh_req_t sh_sel;
	logic sh_dsp;
	logic [4:0] sh_amt;
	logic [39:0] sh_res;
	logic [79:0] sh_wide;

	// DSP instructions win, ALU waits while dsp_sh_i.valid is high
	assign sh_dsp = dsp_sh_i.valid;
	assign sh_sel = sh_dsp ? dsp_sh_i : alu_sh_i;
	assign dsp_sh_gnt_o = dsp_sh_i.valid;
	assign alu_sh_gnt_o = alu_sh_i.valid & ~dsp_sh_i.valid;
	assign sh_amt = (sh_sel.amount > 5'(mdsd_pkg::MDSD_SHAMT_MAX)) ?
		5'(mdsd_pkg::MDSD_SHAMT_MAX) : sh_sel.amount;
	assign sh_wide = {{40{sh_sel.arith & sh_sel.data[39]}}, sh_sel.data};

	always_comb begin
		if (sh_sel.dir == mdsd_pkg::MDSD_SH_LEFT) begin
			sh_res = sh_sel.data << sh_amt;
		end else begin
			sh_res = 40'(sh_wide >> sh_amt);
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alu_sh_o <= 40'h0;
			dsp_sh_o <= 40'h0;
		end else begin
			if (sh_sel.valid && sh_dsp) begin
				dsp_sh_o <= sh_res;
			end
			if (sh_sel.valid && !sh_dsp) begin
				alu_sh_o <= sh_res;
			end
		end
	end

	// ---------------------------------------------------------------
	// Divider
	// ---------------------------------------------------------------
	logic [4:0] step;
	logic [31:0] rem_q;
	logic [15:0] dvs;
	logic neg_q;
	logic neg_r;
	logic [32:0] trial;
	logic [31:0] next_rem_q;
	logic adv;

	// ---------------------------------------------------------------
	// Divider control
	// ---------------------------------------------------------------

	assign adv = div_i.step & ~irq_hold_i;
	assign trial = {rem_q, 1'b0} - {1'b0, dvs, 16'h0};
	assign next_rem_q = trial[32] ? {rem_q[30:0], 1'b0} :
		{trial[31:16], rem_q[14:0], 1'b1};

	// Step counter walks 19 loop cycles; hold keeps it frozen
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step <= mdsd_pkg::MDSD_STEP_RST;
		end else if (adv) begin
			if (step == mdsd_pkg::MDSD_STEP_LAST) begin
				step <= mdsd_pkg::MDSD_STEP_RST;
			end else begin
				step <= step + 5'h01;
			end
		end
	end

	// Load, 16 restoring iterations, sign fix, result
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rem_q <= 32'h0;
			dvs <= 16'h0;
			neg_q <= 1'b0;
			neg_r <= 1'b0;
		end else if (adv) begin
			if (step == mdsd_pkg::MDSD_STEP_LOAD) begin
				logic sgn;
				logic [31:0] n;
				logic [15:0] d;
				sgn = (div_i.mode == mdsd_pkg::MDSD_DIV_S16) ||
					(div_i.mode == mdsd_pkg::MDSD_DIV_S32);
				n = div_i.dividend;
				if (div_i.mode == mdsd_pkg::MDSD_DIV_S16) begin
					n = {{16{div_i.dividend[15]}}, div_i.dividend[15:0]};
				end else if (div_i.mode == mdsd_pkg::MDSD_DIV_U16) begin
					n = {16'h0, div_i.dividend[15:0]};
				end
				if (div_i.frac) begin
					n = {n[15:0], 16'h0};
				end
				d = div_i.divisor;
				neg_q <= sgn & (n[31] ^ d[15]);
				neg_r <= sgn & n[31];
				rem_q <= (sgn && n[31]) ? 32'(-n) : n;
				dvs <= (sgn && d[15]) ? 16'(-d) : d;
			end else if (step <= mdsd_pkg::MDSD_STEP_LAST_ITER) begin
				rem_q <= next_rem_q;
			end else if (step == mdsd_pkg::MDSD_STEP_SIGN) begin
				if (neg_q) begin
					rem_q[15:0] <= 16'(-rem_q[15:0]);
				end
				if (neg_r) begin
					rem_q[31:16] <= 16'(-rem_q[31:16]);
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Divider result
	// ---------------------------------------------------------------

	assign div_busy_o = (step != mdsd_pkg::MDSD_STEP_RST);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_res_o <= '0;
			div_done_o <= 1'b0;
		end else begin
			div_done_o <= adv && (step == mdsd_pkg::MDSD_STEP_LAST);
			if (adv && step == mdsd_pkg::MDSD_STEP_LAST) begin
				div_res_o.quot <= rem_q[15:0];
				div_res_o.rem <= rem_q[31:16];
			end
		end
	end

endmodule // mdsd_datapath

// *** rtl/mdsd_pkg.sv ***
package mdsd_pkg;

	// ---------------------------------------------------------------
	// Widths and counts
	// ---------------------------------------------------------------
	localparam int unsigned MDSD_OPW = 16;
	localparam int unsigned MDSD_MULW = 17;
	localparam int unsigned MDSD_SHW = 40;
	localparam int unsigned MDSD_SHAMT_MAX = 16;
	localparam int unsigned MDSD_DIV_CYCLES = 19;
	localparam int unsigned MDSD_DIV_ITERS = 16;
	localparam logic [4:0] MDSD_STEP_RST = 5'h00;
	localparam logic [4:0] MDSD_STEP_LAST = 5'h12;
	localparam logic [4:0] MDSD_STEP_LOAD = 5'h00;
	localparam logic [4:0] MDSD_STEP_FIRST_ITER = 5'h01;
	localparam logic [4:0] MDSD_STEP_LAST_ITER = 5'h10;
	localparam logic [4:0] MDSD_STEP_SIGN = 5'h11;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MDSD_MUL_SS,
		MDSD_MUL_UU,
		MDSD_MUL_SU,
		MDSD_MUL_US
	} mdsd_mul_mode_t;

	typedef enum logic [1:0] {
		MDSD_DIV_S16,
		MDSD_DIV_U16,
		MDSD_DIV_S32,
		MDSD_DIV_U32
	} mdsd_div_mode_t;

	typedef enum logic {
		MDSD_SH_LEFT,
		MDSD_SH_RIGHT
	} mdsd_sh_dir_t;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic valid;
		mdsd_mul_mode_t mode;
		logic [15:0] a;
		logic [15:0] b;
	} mdsd_mul_req_t;

	typedef struct packed {
		logic valid;
		mdsd_sh_dir_t dir;
		logic arith;
		logic [4:0] amount;
		logic [39:0] data;
	} mdsd_sh_req_t;

	typedef struct packed {
		logic step;
		logic frac;
		mdsd_div_mode_t mode;
		logic [31:0] dividend;
		logic [15:0] divisor;
	} mdsd_div_req_t;

	typedef struct packed {
		logic [15:0] quot;
		logic [15:0] rem;
	} mdsd_div_res_t;

endpackage
